// file: burst_sram_map.svh
`ifndef BURST_SRAM_MAP_SVH
`define BURST_SRAM_MAP_SVH

// ------------------------------------------------------------
// Array geometry
// ------------------------------------------------------------
`define ADDR_W        18
`define LANES         4
`define LANE_W        8
`define DATA_W        32
`define WORD_W        36
`define GROUP_W       16
`define OFFSET_W      2

// ------------------------------------------------------------
// Field positions inside a stored word
// ------------------------------------------------------------
`define PARITY_LSB    32

// ------------------------------------------------------------
// Reset and step values
// ------------------------------------------------------------
`define SLEEP_RESET   2'h0
`define ORDER_RESET   2'h3
`define OFFSET_RESET  2'h0
`define OFFSET_STEP   2'h1

// ------------------------------------------------------------
// Timing counts, in MCLK edges
// ------------------------------------------------------------
`define READ_LATENCY  1
`define WRITE_LATENCY 2

`endif

// file: burst_sram_pkg.sv
`include "burst_sram_map.svh"

package burst_sram_pkg;

	// ------------------------------------------------------------
	// Operation carried down the pipeline
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_NONE,
		OP_READ,
		OP_WRITE
	} op_t;

	typedef struct packed {
		op_t                     op;
		logic [`ADDR_W-1:0]      addr;
		logic [`LANES-1:0]       mask_n;
	} stage_t;

	// ------------------------------------------------------------
	// Whole state of the port
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]              sleep_sync;
		logic [1:0]              order_sync;
		logic                    burst_active;
		logic                    burst_write;
		logic [`GROUP_W-1:0]     base;
		logic [`OFFSET_W-1:0]    start;
		logic [`OFFSET_W-1:0]    count;
		stage_t                  s1;
		stage_t                  s2;
		logic                    out_valid;
		logic [`DATA_W-1:0]      out_data;
		logic [`LANES-1:0]       out_parity;
	} state_t;

endpackage

// file: burst_sram_port.sv
`timescale 1ns/10ps
`include "burst_sram_map.svh"

// Contract
// - Sleep request parks device, memory kept
// - Gated clock edge while awake changes only the sleep and order synchronisers
// - Inputs and read data registered on rise
// - Load address when selected and loading
// - Read starts on selected load, strobe high
// - Read data driven after the next edge
// - Drivers follow output enable after first cycle
// - New operation accepted right after read
// - Deselect floats outputs after next edge
// - Burst counter gives four accesses
// - Strap low linear, high interleaved
// - Counter wraps within lowest two bits
// - Advance ignores selects and write strobe
// - Burst keeps direction captured at start
// - Write starts on selected load, strobe low
// - Drivers float the edge after write
// - Write data captured two edges later
// - Only masked-in byte lanes are written
// - First cycle after deselect stays floating
// - Parity bit follows its lane mask
// - Unconnected strap means interleaved order; here only until the second edge after reset, with no pull on the pin
// - Powers up deselected and floating
module burst_sram_port (
	// Clock and reset
	input  wire logic                  MCLK,
	input  wire logic                  ARST_N,
	// Command inputs
	input  wire logic [`ADDR_W-1:0]    ADDR,
	input  wire logic                  CHIP_SELECT_LOW_1_N,
	input  wire logic                  CHIP_SELECT_HIGH_2,
	input  wire logic                  CHIP_SELECT_LOW_3_N,
	input  wire logic                  ADVANCE_OR_LOAD,
	input  wire logic                  WRITE_STROBE_N,
	input  wire logic [`LANES-1:0]     BYTE_LANE_MASK_N,
	input  wire logic                  CLOCK_GATE_N,
	// Static and asynchronous controls
	input  wire logic                  SLEEP_REQUEST,
	input  wire logic                  BURST_ORDER,
	input  wire logic                  OUTPUT_DRIVE_ENABLE_N,
	// Shared data lines
	input  wire logic [`DATA_W-1:0]    DATA_IN,
	output logic      [`DATA_W-1:0]    DATA_OUT,
	output logic                       DATA_OE_N,
	// Shared parity lines
	input  wire logic [`LANES-1:0]     PARITY_IN,
	output logic      [`LANES-1:0]     PARITY_OUT,
	output logic                       PARITY_OE_N
);

	// ------------------------------------------------------------
	// State and storage
	// ------------------------------------------------------------
	burst_sram_pkg::state_t  s;
	burst_sram_pkg::state_t  next_s;
	logic [`WORD_W-1:0]      mem [0:(1<<`ADDR_W)-1];

	logic                    asleep;
	logic                    qual;
	logic                    all_sel;
	logic                    interleaved;
	logic                    commit;
	logic [`WORD_W-1:0]      stored;
	logic [`WORD_W-1:0]      incoming;
	logic [`WORD_W-1:0]      merged;
	logic [`WORD_W-1:0]      fetched;
	logic [`OFFSET_W-1:0]    next_count;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Lanes whose mask bit is low take the new byte and its parity bit.
	function automatic logic [`WORD_W-1:0] lane_merge(
		input logic [`WORD_W-1:0] old_word,
		input logic [`WORD_W-1:0] new_word,
		input logic [`LANES-1:0]  mask_n
	);
		logic [`WORD_W-1:0] w;
		w = old_word;
		for (int i = 0; i < `LANES; i++) begin
			if (!mask_n[i]) begin
				w[i*`LANE_W +: `LANE_W] = new_word[i*`LANE_W +: `LANE_W];
				w[`PARITY_LSB + i]      = new_word[`PARITY_LSB + i];
			end
		end
		return w;
	endfunction

	function automatic logic [`OFFSET_W-1:0] burst_offset(
		input logic                 inter,
		input logic [`OFFSET_W-1:0] start,
		input logic [`OFFSET_W-1:0] count
	);
		logic [`OFFSET_W-1:0] o;
		if (inter) begin
			o = start ^ count;
		end else begin
			o = start + count;
		end
		return o;
	endfunction

	// ------------------------------------------------------------
	// Decode of the present edge
	// ------------------------------------------------------------
	assign asleep      = s.sleep_sync[1];
	assign interleaved = s.order_sync[1];
	assign qual        = !CLOCK_GATE_N && !asleep;
	assign all_sel     = !CHIP_SELECT_LOW_1_N && CHIP_SELECT_HIGH_2 && !CHIP_SELECT_LOW_3_N;
	assign commit      = qual && (s.s2.op == burst_sram_pkg::OP_WRITE);
	assign next_count  = s.count + `OFFSET_STEP;
	assign stored      = mem[s.s1.addr];
	assign incoming    = {PARITY_IN, DATA_IN};
	assign merged      = lane_merge(mem[s.s2.addr], incoming, s.s2.mask_n);

	// A read issued right behind a write to the same word must see the write
	// that completes on the same edge, so the committing word is forwarded.
	always_comb begin
		fetched = stored;
		if (commit && (s.s2.addr == s.s1.addr)) begin
			fetched = lane_merge(stored, incoming, s.s2.mask_n);
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.sleep_sync = {s.sleep_sync[0], SLEEP_REQUEST};
		next_s.order_sync = {s.order_sync[0], BURST_ORDER};
		if (asleep) begin
			// Pending accesses are dropped; the array itself is untouched.
			next_s.burst_active = 1'b0;
			next_s.s1.op        = burst_sram_pkg::OP_NONE;
			next_s.s2.op        = burst_sram_pkg::OP_NONE;
			next_s.out_valid    = 1'b0;
		end else if (qual) begin
			next_s.s2 = s.s1;
			if (ADVANCE_OR_LOAD) begin
				// Selects and write strobe are not looked at here.
				if (s.burst_active) begin
					next_s.count   = next_count;
					next_s.s1.op   = s.burst_write ? burst_sram_pkg::OP_WRITE
					                               : burst_sram_pkg::OP_READ;
					next_s.s1.addr = {s.base, burst_offset(interleaved, s.start, next_count)};
					next_s.s1.mask_n = BYTE_LANE_MASK_N;
				end else begin
					next_s.s1.op = burst_sram_pkg::OP_NONE;
				end
			end else if (all_sel) begin
				next_s.burst_active = 1'b1;
				next_s.burst_write  = !WRITE_STROBE_N;
				next_s.base         = ADDR[`ADDR_W-1:`OFFSET_W];
				next_s.start        = ADDR[`OFFSET_W-1:0];
				next_s.count        = `OFFSET_RESET;
				next_s.s1.addr      = ADDR;
				next_s.s1.mask_n    = BYTE_LANE_MASK_N;
				next_s.s1.op        = WRITE_STROBE_N ? burst_sram_pkg::OP_READ
				                                     : burst_sram_pkg::OP_WRITE;
			end else begin
				next_s.burst_active = 1'b0;
				next_s.s1.op        = burst_sram_pkg::OP_NONE;
			end
			// The output register loads one edge after the read was taken.
			next_s.out_valid = (s.s1.op == burst_sram_pkg::OP_READ);
			if (s.s1.op == burst_sram_pkg::OP_READ) begin
				next_s.out_data   = fetched[`DATA_W-1:0];
				next_s.out_parity = fetched[`PARITY_LSB +: `LANES];
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			s              <= '0;
			s.sleep_sync   <= `SLEEP_RESET;
			s.order_sync   <= `ORDER_RESET;
		end else begin
			s <= next_s;
		end
	end

	// The array has no reset, so its contents survive sleep and stalls.
	always_ff @(posedge MCLK) begin
		if (commit) begin
			mem[s.s2.addr] <= merged;
		end
	end

	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	// The output enable pin acts without the clock on the drivers only,
	// so it is not resynchronised; no state ever depends on it.
	assign DATA_OUT    = s.out_data;
	assign PARITY_OUT  = s.out_parity;
	assign DATA_OE_N   = !(s.out_valid && !OUTPUT_DRIVE_ENABLE_N && !asleep);
	assign PARITY_OE_N = DATA_OE_N;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!ARST_N);

	a_read_output_latency: assert property (
		qual && (s.s1.op == burst_sram_pkg::OP_READ) |=> s.out_valid && (s.out_data == $past(fetched[`DATA_W-1:0]))
	) else $error("read data not loaded one edge after the read");

	a_write_floats_bus: assert property (
		qual && (s.s1.op == burst_sram_pkg::OP_WRITE) |=> DATA_OE_N && PARITY_OE_N
	) else $error("drivers active in the data cycle of a write");

	a_deselect_floats: assert property (
		qual && !ADVANCE_OR_LOAD && !all_sel ##1 qual |=> DATA_OE_N
	) else $error("drivers active after a pipelined deselect");

	a_stall_holds_state: assert property (
		CLOCK_GATE_N && !asleep |=> $stable(s.s1) && $stable(s.s2) && $stable(s.out_data) && $stable(s.count)
	) else $error("state changed on a gated edge");

	a_oe_masks_drive: assert property (
		OUTPUT_DRIVE_ENABLE_N |-> DATA_OE_N && PARITY_OE_N
	) else $error("drivers on while output enable is high");

	a_linear_step: assert property (
		qual && ADVANCE_OR_LOAD && s.burst_active && !interleaved
		|=> s.s1.addr[`OFFSET_W-1:0] == 2'($past(s.s1.addr[`OFFSET_W-1:0]) + 2'h1)
	) else $error("linear burst did not step by one");

	a_burst_keeps_dir: assert property (
		qual && ADVANCE_OR_LOAD && s.burst_active
		|=> s.s1.op == ($past(s.burst_write) ? burst_sram_pkg::OP_WRITE : burst_sram_pkg::OP_READ)
	) else $error("burst changed direction");

	a_load_takes_addr: assert property (
		qual && !ADVANCE_OR_LOAD && all_sel |=> (s.s1.addr == $past(ADDR)) && (s.count == 2'h0)
	) else $error("loaded address not captured");

	a_sleep_floats: assert property (
		asleep |-> DATA_OE_N ##1 (!s.out_valid || !asleep)
	) else $error("drivers active while asleep");

	a_sleep_clears_pipe: assert property (
		asleep |=> !s.burst_active && (s.s1.op == burst_sram_pkg::OP_NONE) && (s.s2.op == burst_sram_pkg::OP_NONE)
	) else $error("pipeline not cleared while asleep");

	a_commit_needs_qual: assert property (
		CLOCK_GATE_N || asleep |-> !commit
	) else $error("write committed on an ignored edge");

	a_stall_holds_burst: assert property (
		CLOCK_GATE_N && !asleep |=> $stable(s.burst_active) && $stable(s.base) && $stable(s.start)
	) else $error("burst state changed on a gated edge");

	a_parity_with_read: assert property (
		qual && (s.s1.op == burst_sram_pkg::OP_READ)
		|=> s.out_parity == $past(fetched[`PARITY_LSB +: `LANES])
	) else $error("read parity not loaded with its data");

	a_read_drives_bus: assert property (
		s.out_valid && !OUTPUT_DRIVE_ENABLE_N && !asleep |-> !DATA_OE_N && !PARITY_OE_N
	) else $error("read result not driven with output enable low");

	a_read_then_load: assert property (
		qual && (s.s1.op == burst_sram_pkg::OP_READ) && !ADVANCE_OR_LOAD && all_sel
		|=> s.s1.op != burst_sram_pkg::OP_NONE
	) else $error("operation right behind a read was refused");

	a_deselect_ends_burst: assert property (
		qual && !ADVANCE_OR_LOAD && !all_sel |=> !s.burst_active && (s.s1.op == burst_sram_pkg::OP_NONE)
	) else $error("deselect did not end the burst");

	a_first_after_deselect: assert property (
		qual && !ADVANCE_OR_LOAD && all_sel && (s.s1.op == burst_sram_pkg::OP_NONE) |=> DATA_OE_N
	) else $error("drivers active in the first cycle after deselect");

	a_advance_idle_none: assert property (
		qual && ADVANCE_OR_LOAD && !s.burst_active |=> s.s1.op == burst_sram_pkg::OP_NONE
	) else $error("advance without a burst started an access");

	a_burst_stays_group: assert property (
		qual && ADVANCE_OR_LOAD && s.burst_active |=> s.s1.addr[`ADDR_W-1:`OFFSET_W] == $past(s.base)
	) else $error("burst left its four-word group");

	a_interleave_step: assert property (
		qual && ADVANCE_OR_LOAD && s.burst_active && interleaved
		|=> s.s1.addr[`OFFSET_W-1:0] == ($past(s.start) ^ 2'($past(s.count) + 2'h1))
	) else $error("interleaved burst offset wrong");

	a_load_takes_dir: assert property (
		qual && !ADVANCE_OR_LOAD && all_sel
		|=> s.s1.op == ($past(WRITE_STROBE_N) ? burst_sram_pkg::OP_READ : burst_sram_pkg::OP_WRITE)
	) else $error("loaded operation has the wrong direction");

	a_load_takes_mask: assert property (
		qual && !ADVANCE_OR_LOAD && all_sel |=> s.s1.mask_n == $past(BYTE_LANE_MASK_N)
	) else $error("lane mask not taken with the load");

	a_advance_takes_mask: assert property (
		qual && ADVANCE_OR_LOAD && s.burst_active
		|=> s.s1.mask_n == $past(BYTE_LANE_MASK_N)
	) else $error("lane mask not taken with the burst beat");

	a_write_reaches_commit: assert property (
		qual && (s.s1.op == burst_sram_pkg::OP_WRITE) ##1 qual |-> commit
	) else $error("write not committed at its data edge");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	// Each one marks a scenario that the bench is meant to reach.
	c_interleaved_burst: cover property (
		qual && !ADVANCE_OR_LOAD && all_sel && interleaved ##1 (qual && ADVANCE_OR_LOAD && s.burst_active) [*3]
	);

	c_sleep_entry: cover property (
		!asleep ##1 asleep ##1 asleep
	);

	c_read_burst: cover property (
		qual && !ADVANCE_OR_LOAD && all_sel && WRITE_STROBE_N ##1 (qual && ADVANCE_OR_LOAD) [*3]
	);

	c_write_then_read: cover property (
		qual && !ADVANCE_OR_LOAD && all_sel && !WRITE_STROBE_N ##1 qual && !ADVANCE_OR_LOAD && all_sel && WRITE_STROBE_N
	);

	c_stall_in_read: cover property (
		qual && (s.s1.op == burst_sram_pkg::OP_READ) ##1 CLOCK_GATE_N ##1 !DATA_OE_N
	);

endmodule // burst_sram_port

// file: pipelined_burst_sram_port_test.sv
`timescale 1ns/10ps
`include "burst_sram_map.svh"

module pipelined_burst_sram_port_test;
	// ----------------------------------------
	// Signals and reference state
	// ----------------------------------------
	typedef struct packed {
		logic               rd;
		logic               wr;
		logic [`ADDR_W-1:0] a;
		logic [`LANES-1:0]  m;
		logic [`WORD_W-1:0] d;
	} slot_t;
	logic               mclk, arst_n, cs1_n, cs2, cs3_n, adv, we_n, cke_n, sleep, order, ode_n;
	logic [`ADDR_W-1:0] addr;
	logic [`LANES-1:0]  mask_n, pin, pout;
	logic [`DATA_W-1:0] din, dout;
	logic               doe_n, poe_n, wr_issue, bact, bwr, bord, ov;
	logic [`WORD_W-1:0] wr_word, ow;
	logic [`WORD_W-1:0] mem [logic [`ADDR_W-1:0]];
	logic [`ADDR_W-1:0] base;
	logic [1:0]         cnt;
	logic [31:0]        lfsr;
	slot_t              s1, s2;
	int                 n_errors, check_count;

	burst_sram_port u_dut (.MCLK(mclk), .ARST_N(arst_n), .ADDR(addr), .CHIP_SELECT_LOW_1_N(cs1_n),
		.CHIP_SELECT_HIGH_2(cs2), .CHIP_SELECT_LOW_3_N(cs3_n), .ADVANCE_OR_LOAD(adv), .WRITE_STROBE_N(we_n),
		.BYTE_LANE_MASK_N(mask_n), .CLOCK_GATE_N(cke_n), .SLEEP_REQUEST(sleep), .BURST_ORDER(order),
		.OUTPUT_DRIVE_ENABLE_N(ode_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(doe_n),
		.PARITY_IN(pin), .PARITY_OUT(pout), .PARITY_OE_N(poe_n));
	sram_ctrl_model u_ctrl (.mclk(mclk), .arst_n(arst_n), .cke_n(cke_n), .issue(wr_issue),
		.word(wr_word), .data(din), .parity(pin));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	function automatic logic [`ADDR_W-1:0] pick(input logic [6:0] i);
		return {i[6] ? 12'hFFF : 12'h000, i[5:0]};
	endfunction

	function automatic logic [`ADDR_W-1:0] beat(input logic [`ADDR_W-1:0] b, input logic [1:0] k, input logic il);
		return {b[`ADDR_W-1:2], il ? b[1:0] ^ k : b[1:0] + k};
	endfunction

	task automatic check(input string what, input logic [`WORD_W-1:0] seen, input logic [`WORD_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Kinds: 0 deselect, 1 load read, 2 load write, 3 advance.
	task automatic step(input int kind, input logic [`ADDR_W-1:0] a, input logic [3:0] m, input logic gate,
			input logic drop);
		slot_t       op;
		logic [31:0] r;
		@(negedge mclk);
		check("data_oe_n", 36'(doe_n), 36'(!(ov && !ode_n)));
		check("parity_oe_n", 36'(poe_n), 36'(!(ov && !ode_n)));
		if (ov)
			check("read_word", {pout, dout}, ow);
		r = rnd();
		op = '0;
		adv = (kind == 3);
		{cs1_n, cs2, cs3_n} = (kind == 3) ? r[2:0] : (kind != 0) ? 3'b010 : (r[2:0] == 3'b010) ? 3'b110 : r[2:0];
		we_n = (kind == 3) ? r[3] : (kind != 2);
		addr = a;
		mask_n = m;
		cke_n = gate;
		ode_n = r[4] & r[5];
		if (!gate && !drop) begin
			if (kind == 1 || kind == 2) begin
				{bact, bwr, base, cnt} = {1'b1, kind == 2, a, 2'h0};
				op.a = a;
			end
			if (kind == 0)
				bact = 1'b0;
			if (kind == 3 && bact) begin
				cnt = cnt + 2'h1;
				op.a = beat(base, cnt, bord);
			end
			if (kind != 0 && bact)
				{op.rd, op.wr} = {!bwr, bwr};
			op.m = m;
			op.d = {r[9:6], rnd()};
		end
		wr_issue = op.wr;
		wr_word = op.d;
		@(posedge mclk);
		if (drop) begin
			{s1, s2, ov, bact} = '0;
		end else if (!gate) begin
			if (s2.wr)
				for (int i = 0; i < 4; i++)
					if (!s2.m[i])
						{mem[s2.a][32+i], mem[s2.a][8*i+:8]} = {s2.d[32+i], s2.d[8*i+:8]};
			ov = s1.rd;
			if (s1.rd)
				ow = mem[s1.a];
			s2 = s1;
			s1 = op;
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (100000) @(posedge mclk);
		n_errors++;
		results();
	end

	initial begin
		logic [31:0] r;
		lfsr = 32'hC1C9734C;
		{arst_n, adv, cs1_n, cs2, cs3_n, we_n, mask_n, cke_n, sleep, order, ode_n} = 14'h0BFB;
		{addr, wr_issue, wr_word, ov, bact, bwr, bord, cnt, base, s1, s2} = '0;
		order = 1'b1;
		bord = 1'b1;
		repeat (16) @(posedge mclk);
		check("reset_oe_n", 36'(doe_n), 36'h1);
		@(negedge mclk);
		arst_n = 1'b1;
		for (int i = 0; i < 128; i++)
			step(2, pick(7'(i)), 4'h0, 1'b0, 1'b0);
		for (int ph = 0; ph < 2; ph++) begin
			order = (ph == 0);
			bord = order;
			repeat (4) step(0, '0, 4'hF, 1'b0, 1'b0);
			for (int n = 0; n < 500; n++) begin
				r = rnd();
				step(int'(r[1:0]), pick(r[14:8]), r[19:16], r[4:2] == 3'h0, 1'b0);
			end
		end
		repeat (3) step(0, '0, 4'hF, 1'b0, 1'b0);
		sleep = 1'b1;
		repeat (3) step(0, '0, 4'hF, 1'b0, 1'b0);
		repeat (4) step(1, 18'h00005, 4'h0, 1'b0, 1'b1);
		sleep = 1'b0;
		repeat (3) step(0, '0, 4'hF, 1'b0, 1'b0);
		step(1, 18'h00005, 4'h0, 1'b0, 1'b0);
		repeat (2) step(0, '0, 4'hF, 1'b0, 1'b0);
		results();
	end
endmodule // pipelined_burst_sram_port_test

// file: sram_ctrl_model.sv
`timescale 1ns/10ps
`include "burst_sram_map.svh"

module sram_ctrl_model (
	// Clock, reset and clock gate
	input  wire logic               mclk,
	input  wire logic               arst_n,
	input  wire logic               cke_n,
	// Write word handed over at the issue edge
	input  wire logic               issue,
	input  wire logic [`WORD_W-1:0] word,
	// Shared lines toward the port
	output logic      [`DATA_W-1:0] data,
	output logic      [`LANES-1:0]  parity
);
	// ----------------------------------------
	// Write data phase
	// ----------------------------------------
	logic [`WORD_W:0] held;

	// Outside the data phase the lines toggle, so a stale word can never pass for a capture.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			held <= '0;
			{parity, data} <= '0;
		end else if (!cke_n) begin
			held <= {issue, word};
			{parity, data} <= held[`WORD_W] ? held[`WORD_W-1:0] : ~{parity, data};
		end
	end
endmodule // sram_ctrl_model
